//--- design/cmsg_guard.sv
/*
 CPU mode tracking, exception raising and address translation.
 Assumes a CPU core with one access per cycle and a memory port
 that answers each table read with one rvalid pulse.
 Exception sources, mode requests and system calls are one-cycle pulses.
 The test fuse is a level that already stands when reset is released.
 Register writes come only from the CPU, so their mode is the current one.
 The memory map regions sit in the top two bits of the virtual address.
*/
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/100ps
module cmsg_guard (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [31:0] reg_wdata,
   input  wire logic        reg_wr,
   input  wire logic        reg_rd,
   output wire logic [31:0] reg_rdata,
   input  wire logic        acc_valid,
   input  wire logic [1:0]  acc_kind,
   input  wire logic [23:0] acc_addr,
   output wire logic        acc_done,
   output wire logic        acc_grant,
   output wire logic [1:0]  acc_space,
   output wire logic [21:0] acc_paddr,
   input  wire logic        mode_req,
   input  wire logic [2:0]  mode_req_sel,
   input  wire logic        brk_hit,
   input  wire logic        finj_det,
   input  wire logic        illegal_op,
   input  wire logic        stack_ovf,
   input  wire logic        syscall,
   input  wire logic [3:0]  syscall_vec,
   input  wire logic        return_from_interrupt_op,
   input  wire logic        test_fuse,
   output wire logic        exc_valid,
   output wire logic [23:0] exc_vector,
   output wire logic [3:0]  exc_cause,
   output wire logic [2:0]  cpu_mode,
   output wire logic        tbl_rd,
   output wire logic [23:0] tbl_addr,
   input  wire logic [31:0] tbl_rdata,
   input  wire logic        tbl_rvalid
);
   // ==========================================================
   // State
   typedef struct packed {
      cmsg_pkg::cmsg_mode_t  mode;
      logic                  test_off;
      logic                  loading;
      logic [6:0]            widx;
      logic                  tbl_rd;
      logic [23:0]           tbl_addr;
      logic [23:0]           tbase;
      logic [15:0]           scmsk;
      logic [31:0]           rdata;
      logic                  done;
      logic                  grant;
      logic [1:0]            space;
      logic [21:0]           paddr;
      logic                  exc;
      logic [23:0]           vec;
      cmsg_pkg::cmsg_cause_t cause;
      cmsg_pkg::cmsg_cause_t last;
      logic [23:0]           faddr;
      logic [5:0]            cseg;
   } cmsg_guard_st_t;

   // ==========================================================
   // Working signals
   cmsg_guard_st_t        st_q;
   cmsg_guard_st_t        st_d;
   cmsg_seg_if            sg ();
   logic                  user;
   logic                  perm;
   logic                  a_ok;
   logic [1:0]            a_sp;
   logic [21:0]           a_pa;
   logic [15:0]           pg;
   cmsg_pkg::cmsg_cause_t a_cause;
   cmsg_pkg::cmsg_cause_t x_cause;
   cmsg_pkg::cmsg_mode_t  req_mode;
   logic                  cfg_ok;
   logic                  toff_now;

   // ==========================================================
   // Segment store
   cmsg_seg_store u_store (
      .clk (clk),
      .rst (rst),
      .sg  (sg)
   );

   // ==========================================================
   // Decode helpers
   function automatic logic is_super(input cmsg_pkg::cmsg_mode_t m);
      return m == cmsg_pkg::CMSG_BOOT || m == cmsg_pkg::CMSG_TEST
             || m == cmsg_pkg::CMSG_FW;
   endfunction

   function automatic logic in_rows(input logic [1:0] sp, input logic [21:0] pa);
      return sp == cmsg_pkg::CMSG_SP_NVM
             && pa >= cmsg_pkg::CMSG_NVM_SIZE - cmsg_pkg::CMSG_ROWS_SIZE
             && pa < cmsg_pkg::CMSG_NVM_SIZE;
   endfunction

   function automatic logic may_enter(input cmsg_pkg::cmsg_mode_t cur,
                                      input cmsg_pkg::cmsg_mode_t tgt,
                                      input logic toff);
      logic ok;
      ok = 1'b0;
      unique case (cur)
         cmsg_pkg::CMSG_BOOT: ok = (tgt == cmsg_pkg::CMSG_TEST && !toff)
                                   || tgt == cmsg_pkg::CMSG_FW || tgt == cmsg_pkg::CMSG_SYS;
         cmsg_pkg::CMSG_TEST: ok = tgt == cmsg_pkg::CMSG_FW || tgt == cmsg_pkg::CMSG_SYS;
         cmsg_pkg::CMSG_FW:   ok = tgt == cmsg_pkg::CMSG_SYS || tgt == cmsg_pkg::CMSG_USER;
         cmsg_pkg::CMSG_SYS:  ok = tgt == cmsg_pkg::CMSG_USER;
         cmsg_pkg::CMSG_USER: ok = 1'b0;
         default:             ok = 1'b0;
      endcase
      return ok;
   endfunction

   // ==========================================================
   // Privilege gates
   assign cfg_ok = st_q.mode == cmsg_pkg::CMSG_SYS || is_super(st_q.mode);
   assign toff_now = st_q.test_off || test_fuse;

   // ==========================================================
   // Translation and checking
   assign sg.lk_addr = acc_addr;
   assign sg.cs_idx = st_q.cseg;
   assign user = st_q.mode == cmsg_pkg::CMSG_USER;
   assign pg = sg.lk_w1[15:0] + (acc_addr[23:8] - sg.lk_w0[15:0]);

   always_comb begin
      a_ok = 1'b1;
      a_cause = cmsg_pkg::CMSG_X_NONE;
      a_sp = acc_addr[23:22];
      a_pa = acc_addr[21:0];
      perm = 1'b0;
      unique case (acc_kind)
         cmsg_pkg::CMSG_FETCH: perm = sg.lk_w1[cmsg_pkg::CMSG_W1_X];
         cmsg_pkg::CMSG_READ:  perm = sg.lk_w1[cmsg_pkg::CMSG_W1_R];
         cmsg_pkg::CMSG_WRITE: perm = sg.lk_w1[cmsg_pkg::CMSG_W1_W];
         default:              perm = 1'b0;
      endcase
      if (!user) begin
         a_ok = 1'b1;
      end else if (a_sp == cmsg_pkg::CMSG_SP_SFR) begin
         a_ok = acc_kind != cmsg_pkg::CMSG_FETCH && sg.cs_sfr[acc_addr[10:8]];
      end else begin
         a_sp = sg.lk_w1[cmsg_pkg::CMSG_W1_SP +: 2];
         a_pa = {pg[13:0], acc_addr[7:0]};
         if (sg.lk_multi) begin
            a_ok = 1'b0;
            a_cause = cmsg_pkg::CMSG_X_COLL;
         end else begin
            a_ok = sg.lk_hit && perm && !in_rows(a_sp, a_pa)
                   && a_sp != cmsg_pkg::CMSG_SP_SFR;
         end
      end
      if (!a_ok && a_cause == cmsg_pkg::CMSG_X_NONE) begin
         a_cause = cmsg_pkg::CMSG_X_VIOL;
      end
   end

   // ==========================================================
   // Exception source priority
   always_comb begin
      x_cause = cmsg_pkg::CMSG_X_NONE;
      if (brk_hit) begin
         x_cause = cmsg_pkg::CMSG_X_BRK;
      end else if (finj_det) begin
         x_cause = cmsg_pkg::CMSG_X_FINJ;
      end else if (illegal_op) begin
         x_cause = cmsg_pkg::CMSG_X_ILOP;
      end else if (stack_ovf) begin
         x_cause = cmsg_pkg::CMSG_X_STKO;
      end else if (syscall && user && !st_q.scmsk[syscall_vec]) begin
         x_cause = cmsg_pkg::CMSG_X_SYSC;
      end else if (return_from_interrupt_op && user) begin
         x_cause = cmsg_pkg::CMSG_X_RETU;
      end else if (acc_valid && !a_ok) begin
         x_cause = a_cause;
      end
   end

   assign req_mode = cmsg_pkg::cmsg_mode_t'(mode_req_sel);

   // ==========================================================
   // Next state
   always_comb begin
      st_d = st_q;
      st_d.done = acc_valid;
      st_d.grant = acc_valid && a_ok;
      st_d.exc = 1'b0;
      st_d.tbl_rd = 1'b0;
      st_d.rdata = 32'h0000_0000;
      if (test_fuse) begin
         st_d.test_off = 1'b1;
      end
      if (acc_valid) begin
         st_d.space = a_sp;
         st_d.paddr = a_pa;
         if (user && a_ok && sg.lk_hit && acc_kind == cmsg_pkg::CMSG_FETCH
             && acc_addr[23:22] != cmsg_pkg::CMSG_SP_SFR) begin
            st_d.cseg = sg.lk_idx;
         end
      end
      if (x_cause != cmsg_pkg::CMSG_X_NONE) begin
         st_d.exc = 1'b1;
         st_d.cause = x_cause;
         st_d.last = x_cause;
         st_d.vec = cmsg_pkg::CMSG_VEC_BASE + (24'(x_cause) << cmsg_pkg::CMSG_VEC_SHIFT);
         st_d.mode = cmsg_pkg::CMSG_SYS;
         if (acc_valid && !a_ok) begin
            st_d.faddr = acc_addr;
         end
      end else if (syscall && user) begin
         st_d.mode = cmsg_pkg::CMSG_SYS;
      end else if (mode_req && may_enter(st_q.mode, req_mode, toff_now)) begin
         st_d.mode = req_mode;
      end
      // Table fetch sequencing
      if (st_q.loading && tbl_rvalid) begin
         st_d.widx = st_q.widx + 7'h01;
         if (st_q.widx == cmsg_pkg::CMSG_LAST_WORD) begin
            st_d.loading = 1'b0;
         end else begin
            st_d.tbl_rd = 1'b1;
            st_d.tbl_addr = st_q.tbase + 24'({st_q.widx + 7'h01, 2'h0});
         end
      end
      // Register writes
      if (reg_wr && cfg_ok) begin
         unique case (reg_addr)
            cmsg_pkg::CMSG_OFS_CTRL: begin
               if (reg_wdata[cmsg_pkg::CMSG_CTRL_TOFF]) begin
                  st_d.test_off = 1'b1;
               end
               if (reg_wdata[cmsg_pkg::CMSG_CTRL_LOAD] && !st_q.loading) begin
                  st_d.loading = 1'b1;
                  st_d.widx = 7'h00;
                  st_d.tbl_rd = 1'b1;
                  st_d.tbl_addr = st_q.tbase;
               end
            end
            cmsg_pkg::CMSG_OFS_TBASE: st_d.tbase = reg_wdata[23:0];
            cmsg_pkg::CMSG_OFS_SCMSK: st_d.scmsk = reg_wdata[15:0];
            default: ;
         endcase
      end
      // Register reads
      if (reg_rd) begin
         unique case (reg_addr)
            cmsg_pkg::CMSG_OFS_TBASE: st_d.rdata = {8'h00, st_q.tbase};
            cmsg_pkg::CMSG_OFS_SCMSK: st_d.rdata = {16'h0000, st_q.scmsk};
            cmsg_pkg::CMSG_OFS_FADDR: st_d.rdata = {8'h00, st_q.faddr};
            cmsg_pkg::CMSG_OFS_STAT: begin
               st_d.rdata[cmsg_pkg::CMSG_ST_MODE +: 3] = st_q.mode;
               st_d.rdata[cmsg_pkg::CMSG_ST_TOFF] = st_q.test_off;
               st_d.rdata[cmsg_pkg::CMSG_ST_LOAD] = st_q.loading;
               st_d.rdata[cmsg_pkg::CMSG_ST_CAUSE +: 4] = st_q.last;
               st_d.rdata[cmsg_pkg::CMSG_ST_CSEG +: 6] = st_q.cseg;
            end
            default: st_d.rdata = 32'h0000_0000;
         endcase
      end
   end

   // ==========================================================
   // Table write path
   assign sg.wr_en = st_q.loading && tbl_rvalid;
   assign sg.wr_idx = st_q.widx[6:1];
   assign sg.wr_hi = st_q.widx[0];
   assign sg.wr_data = tbl_rdata;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
         st_q.mode <= cmsg_pkg::CMSG_BOOT;
         st_q.tbase <= cmsg_pkg::CMSG_RST_TBASE;
         st_q.scmsk <= cmsg_pkg::CMSG_RST_SCMSK;
         st_q.cause <= cmsg_pkg::CMSG_X_NONE;
         st_q.last <= cmsg_pkg::CMSG_X_NONE;
      end else begin
         st_q <= st_d;
      end
   end

   // ==========================================================
   // Outputs
   assign reg_rdata = st_q.rdata;
   assign acc_done = st_q.done;
   assign acc_grant = st_q.grant;
   assign acc_space = st_q.space;
   assign acc_paddr = st_q.paddr;
   assign exc_valid = st_q.exc;
   assign exc_vector = st_q.vec;
   assign exc_cause = st_q.cause;
   assign cpu_mode = st_q.mode;
   assign tbl_rd = st_q.tbl_rd;
   assign tbl_addr = st_q.tbl_addr;
endmodule

//--- design/cmsg_pkg.sv
/*
 Constants, types and field layouts for the CPU mode and segment guard.
 Assumes one clock domain and a CPU core that keeps one access in flight.
*/
// ==========================================================
package cmsg_pkg;
   // ==========================================================
   // Modes and causes
   typedef enum logic [2:0] {
      CMSG_BOOT = 3'h0,
      CMSG_TEST = 3'h1,
      CMSG_FW   = 3'h3,
      CMSG_SYS  = 3'h2,
      CMSG_USER = 3'h6
   } cmsg_mode_t;

   typedef enum logic [1:0] {
      CMSG_FETCH = 2'h0,
      CMSG_READ  = 2'h1,
      CMSG_WRITE = 2'h2
   } cmsg_kind_t;

   typedef enum logic [3:0] {
      CMSG_X_NONE = 4'h0,
      CMSG_X_BRK  = 4'h1,
      CMSG_X_FINJ = 4'h2,
      CMSG_X_ILOP = 4'h3,
      CMSG_X_STKO = 4'h4,
      CMSG_X_SYSC = 4'h5,
      CMSG_X_RETU = 4'h6,
      CMSG_X_VIOL = 4'h7,
      CMSG_X_COLL = 4'h8
   } cmsg_cause_t;

   // ==========================================================
   // Vectors and memory map
   localparam logic [23:0] CMSG_VEC_BASE = 24'h00_0000;
   localparam int          CMSG_VEC_SHIFT = 3;
   localparam logic [1:0]  CMSG_SP_RAM  = 2'h0;
   localparam logic [1:0]  CMSG_SP_ROM  = 2'h1;
   localparam logic [1:0]  CMSG_SP_NVM  = 2'h2;
   localparam logic [1:0]  CMSG_SP_SFR  = 2'h3;
   localparam logic [21:0] CMSG_NVM_SIZE = 22'h04_0000;
   localparam logic [21:0] CMSG_ROWS_SIZE = 22'h00_0100;

   // ==========================================================
   // Registers
   localparam logic [7:0]  CMSG_OFS_CTRL  = 8'h00;
   localparam logic [7:0]  CMSG_OFS_TBASE = 8'h04;
   localparam logic [7:0]  CMSG_OFS_SCMSK = 8'h08;
   localparam logic [7:0]  CMSG_OFS_STAT  = 8'h0C;
   localparam logic [7:0]  CMSG_OFS_FADDR = 8'h10;
   localparam int          CMSG_CTRL_LOAD = 0;
   localparam int          CMSG_CTRL_TOFF = 1;
   localparam int          CMSG_ST_MODE  = 0;
   localparam int          CMSG_ST_TOFF  = 3;
   localparam int          CMSG_ST_LOAD  = 4;
   localparam int          CMSG_ST_CAUSE = 8;
   localparam int          CMSG_ST_CSEG  = 12;
   localparam logic [23:0] CMSG_RST_TBASE = 24'h00_0000;
   localparam logic [15:0] CMSG_RST_SCMSK = 16'h0000;

   // ==========================================================
   // Segment table entry
   localparam int         CMSG_SEGS    = 64;
   localparam logic [6:0] CMSG_LAST_WORD = 7'h7F;
   localparam int         CMSG_W1_SFR  = 16;
   localparam int         CMSG_W1_EN   = 24;
   localparam int         CMSG_W1_R    = 25;
   localparam int         CMSG_W1_W    = 26;
   localparam int         CMSG_W1_X    = 27;
   localparam int         CMSG_W1_SP   = 28;
endpackage

//--- design/cmsg_seg_if.sv
/*
 Carrier between the guard and its segment store.
 Assumes both ends sit in the same clock domain.
*/
`timescale 1ns/100ps
interface cmsg_seg_if;
   logic        wr_en;
   logic [5:0]  wr_idx;
   logic        wr_hi;
   logic [31:0] wr_data;
   logic [23:0] lk_addr;
   logic        lk_hit;
   logic        lk_multi;
   logic [5:0]  lk_idx;
   logic [31:0] lk_w0;
   logic [31:0] lk_w1;
   logic [5:0]  cs_idx;
   logic [7:0]  cs_sfr;
   modport ctrl (output wr_en, wr_idx, wr_hi, wr_data, lk_addr, cs_idx,
                 input lk_hit, lk_multi, lk_idx, lk_w0, lk_w1, cs_sfr);
   modport store (input wr_en, wr_idx, wr_hi, wr_data, lk_addr, cs_idx,
                  output lk_hit, lk_multi, lk_idx, lk_w0, lk_w1, cs_sfr);
endinterface

//--- design/cmsg_seg_store.sv
/*
 Storage of the 64 user segments and the address lookup over them.
 Assumes writes come only from the table fetch of the guard.
*/
`timescale 1ns/100ps
module cmsg_seg_store (
   input wire logic clk,
   input wire logic rst,
   cmsg_seg_if.store sg
);
   typedef struct packed {
      logic [31:0] w0;
      logic [31:0] w1;
   } cmsg_ent_t;
   typedef struct packed {
      cmsg_ent_t [cmsg_pkg::CMSG_SEGS-1:0] ent;
   } cmsg_store_st_t;

   cmsg_store_st_t                  st_q;
   cmsg_store_st_t                  st_d;
   logic [cmsg_pkg::CMSG_SEGS-1:0]  match;

   // ==========================================================
   // Per segment window match
   genvar g;
   generate
      for (g = 0; g < cmsg_pkg::CMSG_SEGS; g++) begin : g_m
         assign match[g] = st_q.ent[g].w1[cmsg_pkg::CMSG_W1_EN]
                           && sg.lk_addr[23:8] >= st_q.ent[g].w0[15:0]
                           && sg.lk_addr[23:8] <= st_q.ent[g].w0[31:16];
      end
   endgenerate

   // ==========================================================
   // Lowest index wins, overlap flagged
   always_comb begin
      sg.lk_hit = 1'b0;
      sg.lk_multi = 1'b0;
      sg.lk_idx = 6'h00;
      for (int i = 0; i < cmsg_pkg::CMSG_SEGS; i++) begin
         if (match[i]) begin
            if (sg.lk_hit) begin
               sg.lk_multi = 1'b1;
            end else begin
               sg.lk_hit = 1'b1;
               sg.lk_idx = 6'(i);
            end
         end
      end
      sg.lk_w0 = st_q.ent[sg.lk_idx].w0;
      sg.lk_w1 = st_q.ent[sg.lk_idx].w1;
      sg.cs_sfr = st_q.ent[sg.cs_idx].w1[cmsg_pkg::CMSG_W1_EN]
                  ? st_q.ent[sg.cs_idx].w1[cmsg_pkg::CMSG_W1_SFR +: 8] : 8'h00;
   end

   // ==========================================================
   // Table write
   always_comb begin
      st_d = st_q;
      if (sg.wr_en) begin
         if (sg.wr_hi) begin
            st_d.ent[sg.wr_idx].w1 = sg.wr_data;
         end else begin
            st_d.ent[sg.wr_idx].w0 = sg.wr_data;
         end
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
endmodule

//--- test/cmsg_tbl_mem.sv
/*
 Behavioural memory that holds the segment table read by the guard.
 Assumes one table read in flight and 128 words placed at base.
*/
`timescale 1ns/100ps
module cmsg_tbl_mem (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        tbl_rd,
   input  wire logic [23:0] tbl_addr,
   input  wire logic [23:0] base,
   input  wire logic [3:0]  dly,
   output logic [31:0]      tbl_rdata,
   output logic             tbl_rvalid
);
   logic [31:0] mem [128];
   logic [23:0] ofs_q;
   logic [3:0]  cnt_q;
   logic        busy_q;
   // ==========
   // Read port
   // Answers each read once, after dly idle cycles
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         busy_q     <= 1'b0;
         cnt_q      <= 4'h0;
         ofs_q      <= 24'h00_0000;
         tbl_rvalid <= 1'b0;
         tbl_rdata  <= 32'h0000_0000;
      end else begin
         tbl_rvalid <= 1'b0;
         tbl_rdata  <= ~tbl_rdata;
         if (tbl_rd) begin
            busy_q <= 1'b1;
            cnt_q  <= dly;
            ofs_q  <= tbl_addr - base;
         end else if (busy_q && cnt_q != 4'h0) begin
            cnt_q <= cnt_q - 4'h1;
         end else if (busy_q) begin
            busy_q     <= 1'b0;
            tbl_rvalid <= 1'b1;
            tbl_rdata  <= mem[ofs_q[8:2]];
         end
      end
   end
endmodule

//--- test/cmsg_guard_chk.sv
/*
 Port checks on the mode and segment guard.
 Assumes the guard's clk and rst; bound to every guard instance.
*/
`timescale 1ns/100ps
module cmsg_guard_chk (
   input wire logic        clk,
   input wire logic        rst,
   input wire logic        acc_valid,
   input wire logic [23:0] acc_addr,
   input wire logic        acc_done,
   input wire logic        acc_grant,
   input wire logic [21:0] acc_paddr,
   input wire logic        brk_hit,
   input wire logic        test_fuse,
   input wire logic        exc_valid,
   input wire logic [23:0] exc_vector,
   input wire logic [3:0]  exc_cause,
   input wire logic [2:0]  cpu_mode,
   input wire logic        tbl_rd
);
   logic [21:0] va_lo;
   assign va_lo = acc_addr[21:0];
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   // ==========
   // Assertions
   chk_acc_answered: assert property (acc_valid |=> acc_done)
      else $error("access not answered");
   chk_exc_sys_mode: assert property (exc_valid |-> cpu_mode == 3'h2)
      else $error("exception without system mode");
   chk_exc_vector: assert property (exc_valid |-> exc_vector == {17'h0_0000, exc_cause, 3'h0})
      else $error("exception vector wrong");
   chk_brk_cause: assert property (brk_hit |=> exc_valid && exc_cause == 4'h1)
      else $error("breakpoint not raised");
   chk_boot_once: assert property (cpu_mode != 3'h0 |=> cpu_mode != 3'h0)
      else $error("boot mode entered again");
   chk_fw_entry: assert property (cpu_mode == 3'h3 && $past(cpu_mode) != 3'h3 |-> $past(cpu_mode) inside {3'h0, 3'h1})
      else $error("firmware mode reached from below");
   chk_test_locked: assert property (test_fuse && cpu_mode != 3'h1 |=> cpu_mode != 3'h1)
      else $error("test mode entered while locked");
   chk_priv_grant: assert property (acc_valid && cpu_mode != 3'h6 |=> acc_grant && acc_paddr == $past(va_lo))
      else $error("privileged access not passed through");
   cov_collide: cover property (exc_valid && exc_cause == 4'h8);
   cov_deny: cover property (acc_done && !acc_grant);
   cov_load: cover property (tbl_rd);
endmodule
bind cmsg_guard cmsg_guard_chk i_chk (.clk, .rst, .acc_valid, .acc_addr, .acc_done, .acc_grant, .acc_paddr,
   .brk_hit, .test_fuse, .exc_valid, .exc_vector, .exc_cause, .cpu_mode, .tbl_rd);

//--- test/cpu_mode_and_segment_guard_bench.sv
/*
 Self-checking bench for the mode and segment guard.
 Assumes the table memory model and the bound checker.
*/
`timescale 1ns/100ps
module cpu_mode_and_segment_guard_bench;
   typedef struct packed {
      logic [1:0]  k;
      logic [23:0] a;
      logic        g;
      logic [1:0]  sp;
      logic [21:0] pa;
      logic [3:0]  c;
   } cmsg_row_t;
   logic        clk, rst, reg_wr, reg_rd, test_fuse;
   logic [7:0]  reg_addr, pl;
   logic [31:0] reg_wdata, d;
   logic [1:0]  acc_kind;
   logic [23:0] acc_addr;
   logic [2:0]  mode_req_sel;
   logic [3:0]  syscall_vec, dly;
   wire logic   acc_valid, mode_req, brk_hit, finj_det, illegal_op, stack_ovf, syscall, return_from_interrupt_op;
   wire logic [31:0] reg_rdata, tbl_rdata;
   wire logic [23:0] exc_vector, tbl_addr;
   wire logic [21:0] acc_paddr;
   wire logic [3:0]  exc_cause;
   wire logic [2:0]  cpu_mode;
   wire logic [1:0]  acc_space;
   wire logic        acc_done, acc_grant, exc_valid, tbl_rd, tbl_rvalid;
   int          bad_count, n_tests;
   // Segments 0 to 5: words low then high
   localparam logic [31:0] tw [12] = '{32'h0010_0010, 32'h0B04_0020, 32'h0021_0020, 32'h2700_03FE,
      32'h0030_0030, 32'h0E00_0000, 32'h0041_0040, 32'h0300_0100, 32'h0041_0041, 32'h0300_0200,
      32'h0050_0050, 32'h3300_0000};
   // Request, expected mode
   localparam logic [5:0] mw [6] = '{6'h09, 6'h1B, 6'h12, 6'h1A, 6'h02, 6'h0A};
   // Source pattern, expected cause
   localparam logic [11:0] xs [7] = '{12'h201, 12'h102, 12'h083, 12'h044, 12'h025, 12'h016, 12'h301};
   localparam cmsg_row_t rows [13] = '{
      {2'h0, 24'h00_1004, 1'b1, 2'h0, 22'h00_2004, 4'h0}, {2'h2, 24'h00_1008, 1'b0, 2'h0, 22'h0, 4'h7},
      {2'h2, 24'h00_2010, 1'b1, 2'h2, 22'h03_FE10, 4'h0}, {2'h0, 24'h00_2010, 1'b0, 2'h0, 22'h0, 4'h7},
      {2'h1, 24'h00_21F0, 1'b0, 2'h0, 22'h0, 4'h7}, {2'h1, 24'h00_3000, 1'b0, 2'h0, 22'h0, 4'h7},
      {2'h1, 24'h00_4100, 1'b0, 2'h0, 22'h0, 4'h8}, {2'h1, 24'h00_4000, 1'b1, 2'h0, 22'h01_0000, 4'h0},
      {2'h1, 24'h00_5000, 1'b0, 2'h0, 22'h0, 4'h7}, {2'h1, 24'hC0_0200, 1'b1, 2'h3, 22'h0, 4'h0},
      {2'h1, 24'hC0_0100, 1'b0, 2'h0, 22'h0, 4'h7}, {2'h0, 24'hC0_0200, 1'b0, 2'h0, 22'h0, 4'h7},
      {2'h1, 24'h00_0000, 1'b0, 2'h0, 22'h0, 4'h7}};
   assign {acc_valid, mode_req, brk_hit, finj_det, illegal_op, stack_ovf, syscall, return_from_interrupt_op} = pl;
   cmsg_guard i_dut (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .acc_valid, .acc_kind,
      .acc_addr, .acc_done, .acc_grant, .acc_space, .acc_paddr, .mode_req, .mode_req_sel, .brk_hit, .finj_det,
      .illegal_op, .stack_ovf, .syscall, .syscall_vec, .return_from_interrupt_op, .test_fuse, .exc_valid,
      .exc_vector, .exc_cause, .cpu_mode, .tbl_rd, .tbl_addr, .tbl_rdata, .tbl_rvalid);
   cmsg_tbl_mem i_mem (.clk, .rst, .tbl_rd, .tbl_addr, .base(24'h00_0400), .dly, .tbl_rdata, .tbl_rvalid);
   // ==========
   // Tasks
   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic pulse(input logic [7:0] p);
      @(posedge clk);
      pl <= p;
      @(posedge clk);
      pl <= 8'h00;
      #1;
   endtask
   task automatic mode(input logic [2:0] s);
      mode_req_sel <= s;
      pulse(8'h40);
   endtask
   task automatic acc(input logic [1:0] k, input logic [23:0] a);
      acc_kind <= k;
      acc_addr <= a;
      pulse(8'h80);
   endtask
   task automatic reg_io(input logic w, input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      reg_addr  <= a;
      reg_wdata <= v;
      reg_wr    <= w;
      reg_rd    <= !w;
      @(posedge clk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask
   task automatic exc(input logic [3:0] c);
      check("exc_valid", exc_valid, c != 4'h0);
      if (c != 4'h0) begin
         check("exc_cause", exc_cause, c);
         check("exc_vector", exc_vector, {c, 3'h0});
         check("cpu_mode", cpu_mode, 3'h2);
      end
   endtask
   task automatic do_reset;
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      #1;
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ==========
   // Clock and watchdog
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #50000;
      bad_count++;
      summarize;
   end
   // ==========
   // Main sequence
   initial begin
      {rst, pl, reg_addr, reg_wdata, reg_wr, reg_rd, acc_kind, acc_addr} = {1'b1, 76'h0};
      {mode_req_sel, syscall_vec, test_fuse, dly, bad_count, n_tests} = '0;
      for (int i = 0; i < 128; i++) i_mem.mem[i] = (i < 12) ? tw[i] : 32'h0000_0000;
      do_reset;
      check("reset mode", cpu_mode, 3'h0);
      reg_io(1'b0, 8'h0C, 32'h0);
      check("status", d, 32'h0);
      acc(2'h1, 24'hC0_0123);
      check("boot grant", acc_grant, 1'b1);
      check("boot paddr", acc_paddr, 22'h00_0123);
      $display("test reset done");
      foreach (mw[i]) begin
         mode(mw[i][5:3]);
         check("mode", cpu_mode, mw[i][2:0]);
      end
      $display("test modes done");
      reg_io(1'b1, 8'h04, 32'h0000_0400);
      reg_io(1'b1, 8'h08, 32'h0000_0008);
      reg_io(1'b0, 8'hFC, 32'h0);
      check("unmapped", d, 32'h0);
      reg_io(1'b1, 8'h00, 32'h0000_0001);
      d = 32'h10;
      for (int n = 0; n < 1000 && d[4] !== 1'b0; n++) begin
         dly <= n[0] ? 4'h0 : 4'h5;
         reg_io(1'b0, 8'h0C, 32'h0);
      end
      check("status", d, 32'h0000_0002);
      $display("test table load done");
      foreach (rows[i]) begin
         if (cpu_mode !== 3'h6) mode(3'h6);
         acc(rows[i].k, rows[i].a);
         check("acc_done", acc_done, 1'b1);
         check("acc_grant", acc_grant, rows[i].g);
         if (rows[i].g && rows[i].sp != 2'h3) begin
            check("acc_space", acc_space, rows[i].sp);
            check("acc_paddr", acc_paddr, rows[i].pa);
         end
         exc(rows[i].c);
      end
      $display("test segments done");
      mode(3'h6);
      for (int s = 0; s < 4; s++) begin
         mode(s[2:0]);
         check("user mode", cpu_mode, 3'h6);
      end
      reg_io(1'b1, 8'h04, 32'h0000_0800);
      reg_io(1'b0, 8'h04, 32'h0);
      check("user write", d, 32'h0000_0400);
      syscall_vec <= 4'h3;
      pulse(8'h02);
      check("syscall mode", cpu_mode, 3'h2);
      syscall_vec <= 4'h4;
      foreach (xs[i]) begin
         mode(3'h6);
         pulse(xs[i][11:4]);
         exc(xs[i][3:0]);
      end
      $display("test exceptions done");
      reg_io(1'b1, 8'h00, 32'h0000_0002);
      reg_io(1'b0, 8'h0C, 32'h0);
      check("status", d, 32'h0000_010A);
      test_fuse <= 1'b1;
      do_reset;
      mode(3'h1);
      check("locked", cpu_mode, 3'h0);
      reg_io(1'b0, 8'h0C, 32'h0);
      check("status", d, 32'h0000_0008);
      mode(3'h2);
      mode(3'h6);
      acc(2'h0, 24'h00_1004);
      exc(4'h7);
      reg_io(1'b0, 8'h10, 32'h0);
      check("faddr", d, 32'h0000_1004);
      $display("test lock done");
      summarize;
   end
endmodule
